// *** common/cpi_defs.svh ***
// constants for the processor-side priority and software interrupt registers
`ifndef CPI_DEFS_SVH
`define CPI_DEFS_SVH

// ----------------------------------------------------------------
// system register encodings
// ----------------------------------------------------------------
`define CPI_PMR_OP1 3'h0
`define CPI_PMR_CRN 4'h4
`define CPI_PMR_CRM 4'h6
`define CPI_PMR_OP2 3'h0
`define CPI_RPR_OP1 3'h0
`define CPI_RPR_CRN 4'hC
`define CPI_RPR_CRM 4'hB
`define CPI_RPR_OP2 3'h3
`define CPI_SGI0_OP1 3'h0
`define CPI_SGI0_CRN 4'hC
`define CPI_SGI0_CRM 4'hB
`define CPI_SGI0_OP2 3'h7

// ----------------------------------------------------------------
// field positions of the generate register
// ----------------------------------------------------------------
`define CPI_AFFINITY_LEVEL_THREE_HI 55
`define CPI_AFFINITY_LEVEL_THREE_LO 48
`define CPI_MODE_BIT 40
`define CPI_AFFINITY_LEVEL_TWO_HI 39
`define CPI_AFFINITY_LEVEL_TWO_LO 32
`define CPI_ID_HI 27
`define CPI_ID_LO 24
`define CPI_AFFINITY_LEVEL_ONE_HI 23
`define CPI_AFFINITY_LEVEL_ONE_LO 16
`define CPI_TGT_HI 15
`define CPI_TGT_LO 0

// ----------------------------------------------------------------
// reset and idle values, exception level codes
// ----------------------------------------------------------------
`define CPI_PMR_RESET 8'h00
`define CPI_IDLE_PRIO 8'hFF
`define CPI_EL0 2'h0
`define CPI_EL1 2'h1
`define CPI_EL2 2'h2
`define CPI_EL3 2'h3

`endif

// *** common/cpi_pkg.sv ***
// types shared by the priority and software interrupt register block
package cpi_pkg;
  // register addressed by an access
  typedef enum logic [1:0] {SEL_NONE, SEL_PMR, SEL_RPR, SEL_SGI0} cpi_sel_t;
  // outcome of the access check
  typedef enum logic [1:0] {ACC_OK, ACC_TRAP, ACC_VIRT, ACC_UNDEF} cpi_acc_t;
  // request handling state
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT_GEN} cpi_state_t;
endpackage

// *** hdl/cpi_access_check.sv ***
// trap, redirect and undefined decision for one system register access
`timescale 1ns/1ps
`default_nettype none
`include "cpi_defs.svh"
module cpi_access_check
  import cpi_pkg::*;
(
  input wire cpi_sel_t sel,
  input wire logic is_write,
  input wire logic [1:0] el,
  input wire logic security_state_bit,
  input wire logic hyp_fiq_route,
  input wire logic hyp_irq_route,
  input wire logic hyp_common_reg_trap,
  input wire logic sysreg_enable_level1,
  input wire logic sysreg_enable_level2,
  input wire logic sysreg_enable_level3,
  input wire logic el3_present,
  input wire logic secure_monitor_fiq_route,
  input wire logic secure_monitor_irq_route,
  output cpi_acc_t acc,
  output logic [1:0] trap_el
);
  logic ns_el1;
  logic hyp_route;
  logic sre_off;
  logic bad_dir;
  logic mon_trap;

  // ----------------------------------------------------------------
  // condition terms
  // ----------------------------------------------------------------
  assign ns_el1 = (el == `CPI_EL1) && security_state_bit;
  assign hyp_route = hyp_fiq_route | hyp_irq_route;
  assign sre_off = ((el == `CPI_EL1) && !sysreg_enable_level1) ||
                   ((el == `CPI_EL2) && !sysreg_enable_level2) ||
                   ((el == `CPI_EL3) && !sysreg_enable_level3);
  assign bad_dir = ((sel == SEL_RPR) && is_write) ||
                   ((sel == SEL_SGI0) && !is_write);
  assign mon_trap = el3_present && secure_monitor_fiq_route && secure_monitor_irq_route &&
                    (((el == `CPI_EL1) && !security_state_bit) || (el == `CPI_EL2) ||
                     (ns_el1 && !hyp_route));

  // priority of the outcomes
  always_comb begin
    acc = ACC_OK;
    trap_el = el;
    if ((sel == SEL_NONE) || (el == `CPI_EL0) || bad_dir) begin
      acc = ACC_UNDEF;
    end else if (sre_off) begin
      acc = ACC_TRAP;
    end else if (ns_el1 && hyp_route) begin
      if (sel == SEL_SGI0) begin
        acc = ACC_TRAP;
        trap_el = `CPI_EL2;
      end else begin
        acc = ACC_VIRT;
      end
    end else if (ns_el1 && hyp_common_reg_trap) begin
      acc = ACC_TRAP;
      trap_el = `CPI_EL2;
    end else if (mon_trap) begin
      acc = ACC_TRAP;
      trap_el = `CPI_EL3;
    end
  end
endmodule
`default_nettype wire

// *** hdl/cpi_sgi_builder.sv ***
// builds and holds one generate packet until the distributor takes it
`timescale 1ns/1ps
`default_nettype none
`include "cpi_defs.svh"
module cpi_sgi_builder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [63:0] wdata,
  input wire logic gen_ready,
  output logic gen_valid,
  output logic [3:0] gen_interrupt_identifier,
  output logic gen_routing_mode,
  output logic [7:0] gen_affinity_level_three,
  output logic [7:0] gen_affinity_level_two,
  output logic [7:0] gen_affinity_level_one,
  output logic [15:0] gen_target_bitmap
);
  logic mode;

  assign mode = wdata[`CPI_MODE_BIT];

  // packet valid until accepted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_valid <= 1'b0;
    end else if (load) begin
      gen_valid <= 1'b1;
    end else if (gen_ready) begin
      gen_valid <= 1'b0;
    end
  end

  // packet fields, targeting cleared in broadcast mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_interrupt_identifier <= 4'h0;
      gen_routing_mode <= 1'b0;
      gen_affinity_level_three <= 8'h00;
      gen_affinity_level_two <= 8'h00;
      gen_affinity_level_one <= 8'h00;
      gen_target_bitmap <= 16'h0000;
    end else if (load) begin
      gen_interrupt_identifier <= wdata[`CPI_ID_HI:`CPI_ID_LO];
      gen_routing_mode <= mode;
      gen_affinity_level_three <= mode ? 8'h00 : wdata[`CPI_AFFINITY_LEVEL_THREE_HI:`CPI_AFFINITY_LEVEL_THREE_LO];
      gen_affinity_level_two <= mode ? 8'h00 : wdata[`CPI_AFFINITY_LEVEL_TWO_HI:`CPI_AFFINITY_LEVEL_TWO_LO];
      gen_affinity_level_one <= mode ? 8'h00 : wdata[`CPI_AFFINITY_LEVEL_ONE_HI:`CPI_AFFINITY_LEVEL_ONE_LO];
      gen_target_bitmap <= mode ? 16'h0000 : wdata[`CPI_TGT_HI:`CPI_TGT_LO];
    end
  end
endmodule
`default_nettype wire

// *** hdl/cpi_regs.sv ***
// priority mask, running priority and group 0 generate system registers
//
// Functional notes
// - mask register read and written at op1 0, CRn 4, CRm 6, op2 0.
// - non-secure level 1 reaches mask only with both hypervisor routes clear.
// - pending interrupt signalled only when its priority is below the mask.
// - disabled system register interface at a level traps accesses to that level.
// - non-secure level 1 accesses trap to level 2 under common-register trap.
// - both monitor routes set trap level 1, 2 accesses to level 3.
// - running priority is read-only, priority in bits 7:0, zero above.
// - running priority is group priority of the active interrupt.
// - no active or all dropped gives the idle priority.
// - group priority uses priority bits 7:1 with bit 0 cleared.
// - running priority at op1 0, CRn 12, CRm 11, op2 3, virtual when routed.
// - generate register write raises secure group 0 software interrupts.
// - generate layout: affinities, mode bit 40, identifier, target bitmap.
// - interrupt identifier comes from bits 27:24.
// - mode 0 targets affinity path plus bitmap, mode 1 all but self.
// - in mode 1 the affinity and bitmap fields are forced to zero.
// - bitmap bit n selects affinity-0 value n in the cluster.
`timescale 1ns/1ps
`default_nettype none
`include "cpi_defs.svh"
module cpi_regs
  import cpi_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // system register access port
  input wire logic sr_req,
  input wire logic sr_write,
  input wire logic [2:0] sr_op1,
  input wire logic [3:0] sr_crn,
  input wire logic [3:0] sr_crm,
  input wire logic [2:0] sr_op2,
  input wire logic [1:0] sr_el,
  input wire logic [63:0] sr_wdata,
  output logic sr_ready,
  output logic sr_done,
  output logic [63:0] sr_rdata,
  output logic sr_trap,
  output logic [1:0] sr_trap_el,
  output logic sr_virtual,
  output logic sr_undef,
  // processor state controlling traps and redirects
  input wire logic security_state_bit,
  input wire logic hyp_fiq_route,
  input wire logic hyp_irq_route,
  input wire logic hyp_common_reg_trap,
  input wire logic sysreg_enable_level1,
  input wire logic sysreg_enable_level2,
  input wire logic sysreg_enable_level3,
  input wire logic el3_present,
  input wire logic secure_monitor_fiq_route,
  input wire logic secure_monitor_irq_route,
  // active and pending interrupt state of the interface
  input wire logic act_valid,
  input wire logic act_all_dropped,
  input wire logic [7:0] act_priority,
  input wire logic pend_valid,
  input wire logic [7:0] pend_priority,
  output logic irq_signal,
  output logic [7:0] priority_mask_value,
  // generate packet toward the distributor
  input wire logic gen_ready,
  output logic gen_valid,
  output logic [3:0] gen_interrupt_identifier,
  output logic gen_routing_mode,
  output logic [7:0] gen_affinity_level_three,
  output logic [7:0] gen_affinity_level_two,
  output logic [7:0] gen_affinity_level_one,
  output logic [15:0] gen_target_bitmap
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cpi_sel_t sel;
  cpi_acc_t acc;

  cpi_state_t state_reg;
  cpi_state_t state_next;

  logic [1:0] trap_el;
  logic take;
  logic ok_access;
  logic gen_load;
  logic gen_taken;

  logic [7:0] pmr_reg;
  logic [7:0] pmr_next;

  logic [7:0] rpr_reg;
  logic [7:0] rpr_next;
  logic [7:0] group_prio;

  logic rdone_reg;
  logic [63:0] rdata_reg;
  logic trap_reg;
  logic [1:0] trap_el_reg;
  logic virt_reg;
  logic undef_reg;

  logic irq_reg;

  // ----------------------------------------------------------------
  // encoding decode
  // ----------------------------------------------------------------
  // map the instruction encoding onto one of the three registers
  always_comb begin
    sel = SEL_NONE;
    if (sr_op1 == `CPI_PMR_OP1 && sr_crn == `CPI_PMR_CRN &&
        sr_crm == `CPI_PMR_CRM && sr_op2 == `CPI_PMR_OP2) begin
      sel = SEL_PMR;
    end else if (sr_op1 == `CPI_RPR_OP1 && sr_crn == `CPI_RPR_CRN &&
                 sr_crm == `CPI_RPR_CRM && sr_op2 == `CPI_RPR_OP2) begin
      sel = SEL_RPR;
    end else if (sr_op1 == `CPI_SGI0_OP1 && sr_crn == `CPI_SGI0_CRN &&
                 sr_crm == `CPI_SGI0_CRM && sr_op2 == `CPI_SGI0_OP2) begin
      sel = SEL_SGI0;
    end
  end

  // ----------------------------------------------------------------
  // access checking
  // ----------------------------------------------------------------
  cpi_access_check u_check (
    .sel(sel),
    .is_write(sr_write),
    .el(sr_el),
    .security_state_bit(security_state_bit),
    .hyp_fiq_route(hyp_fiq_route),
    .hyp_irq_route(hyp_irq_route),
    .hyp_common_reg_trap(hyp_common_reg_trap),
    .sysreg_enable_level1(sysreg_enable_level1),
    .sysreg_enable_level2(sysreg_enable_level2),
    .sysreg_enable_level3(sysreg_enable_level3),
    .el3_present(el3_present),
    .secure_monitor_fiq_route(secure_monitor_fiq_route),
    .secure_monitor_irq_route(secure_monitor_irq_route),
    .acc(acc),
    .trap_el(trap_el)
  );

  // request taken only while idle; a pending packet stalls the port
  assign sr_ready = (state_reg == ST_IDLE);
  assign take = sr_req && sr_ready;
  assign ok_access = take && (acc == ACC_OK);
  assign gen_load = ok_access && (sel == SEL_SGI0);
  assign gen_taken = gen_valid && gen_ready;

  // ----------------------------------------------------------------
  // request state machine
  // ----------------------------------------------------------------
  // a generate write completes only once the distributor took the packet
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (gen_load) begin
          state_next = ST_WAIT_GEN;
        end
      end
      ST_WAIT_GEN: begin
        if (gen_taken) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // priority mask
  // ----------------------------------------------------------------
  // physical mask written only by an access that passed the check
  always_comb begin
    pmr_next = pmr_reg;
    if (ok_access && sel == SEL_PMR && sr_write) begin
      pmr_next = sr_wdata[7:0];
    end
  end

  // mask storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmr_reg <= `CPI_PMR_RESET;
    end else begin
      pmr_reg <= pmr_next;
    end
  end

  // mask as seen by the interface
  assign priority_mask_value = pmr_reg;

  // ----------------------------------------------------------------
  // pending interrupt filter
  // ----------------------------------------------------------------
  // compared against the post-write mask so a write takes effect at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= pend_valid && (pend_priority < pmr_next);
    end
  end

  // registered pending signal
  assign irq_signal = irq_reg;

  // ----------------------------------------------------------------
  // running priority
  // ----------------------------------------------------------------
  // binary point at its minimum
  assign group_prio = {act_priority[7:1], 1'b0};

  // idle value when nothing is active or all active have dropped
  always_comb begin
    rpr_next = `CPI_IDLE_PRIO;
    if (act_valid && !act_all_dropped) begin
      rpr_next = group_prio;
    end
  end

  // running priority tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rpr_reg <= `CPI_IDLE_PRIO;
    end else begin
      rpr_reg <= rpr_next;
    end
  end

  // ----------------------------------------------------------------
  // response
  // ----------------------------------------------------------------
  // completion pulse: at once for reads, traps and mask writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdone_reg <= 1'b0;
    end else begin
      rdone_reg <= (take && !gen_load) || (state_reg == ST_WAIT_GEN && gen_taken);
    end
  end

  // read data, upper bits always zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 64'h0000_0000_0000_0000;
    end else if (take) begin
      rdata_reg <= 64'h0000_0000_0000_0000;
      if (ok_access && !sr_write && sel == SEL_PMR) begin
        rdata_reg <= {56'h00_0000_0000_0000, pmr_reg};
      end else if (ok_access && !sr_write && sel == SEL_RPR) begin
        rdata_reg <= {56'h00_0000_0000_0000, rpr_reg};
      end
    end
  end

  // trap report
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_reg <= 1'b0;
      trap_el_reg <= `CPI_EL0;
    end else begin
      trap_reg <= take && (acc == ACC_TRAP);
      if (take) begin
        trap_el_reg <= (acc == ACC_TRAP) ? trap_el : `CPI_EL0;
      end
    end
  end

  // redirect to the virtual copy and undefined encodings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      virt_reg <= 1'b0;
      undef_reg <= 1'b0;
    end else begin
      virt_reg <= take && (acc == ACC_VIRT);
      undef_reg <= take && (acc == ACC_UNDEF);
    end
  end

  // registered port responses
  assign sr_done = rdone_reg;
  assign sr_rdata = rdata_reg;
  assign sr_trap = trap_reg;
  assign sr_trap_el = trap_el_reg;
  assign sr_virtual = virt_reg;
  assign sr_undef = undef_reg;

  // ----------------------------------------------------------------
  // generate packet
  // ----------------------------------------------------------------
  // distributor always answers with ready eventually
  cpi_sgi_builder u_sgi (
    .clk(clk),
    .rst_n(rst_n),
    .load(gen_load),
    .wdata(sr_wdata),
    .gen_ready(gen_ready),
    .gen_valid(gen_valid),
    .gen_interrupt_identifier(gen_interrupt_identifier),
    .gen_routing_mode(gen_routing_mode),
    .gen_affinity_level_three(gen_affinity_level_three),
    .gen_affinity_level_two(gen_affinity_level_two),
    .gen_affinity_level_one(gen_affinity_level_one),
    .gen_target_bitmap(gen_target_bitmap)
  );
endmodule
`default_nettype wire

// *** sim/cpi_regs_assertions.sv ***
// concurrent checks on the ports of the priority and generate register block
`timescale 1ns/1ps
`default_nettype none
module cpi_regs_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sr_req,
  input wire logic sr_write,
  input wire logic [2:0] sr_op1,
  input wire logic [3:0] sr_crn,
  input wire logic [3:0] sr_crm,
  input wire logic [2:0] sr_op2,
  input wire logic [1:0] sr_el,
  input wire logic [63:0] sr_wdata,
  input wire logic sr_ready,
  input wire logic sr_done,
  input wire logic sr_trap,
  input wire logic [1:0] sr_trap_el,
  input wire logic sr_virtual,
  input wire logic sr_undef,
  input wire logic security_state_bit,
  input wire logic hyp_fiq_route,
  input wire logic hyp_irq_route,
  input wire logic hyp_common_reg_trap,
  input wire logic sysreg_enable_level1,
  input wire logic sysreg_enable_level2,
  input wire logic el3_present,
  input wire logic secure_monitor_fiq_route,
  input wire logic secure_monitor_irq_route,
  input wire logic pend_valid,
  input wire logic [7:0] pend_priority,
  input wire logic irq_signal,
  input wire logic [7:0] priority_mask_value,
  input wire logic gen_ready,
  input wire logic gen_valid,
  input wire logic [3:0] gen_interrupt_identifier,
  input wire logic gen_routing_mode,
  input wire logic [7:0] gen_affinity_level_three,
  input wire logic [7:0] gen_affinity_level_two,
  input wire logic [7:0] gen_affinity_level_one,
  input wire logic [15:0] gen_target_bitmap
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire tk = sr_req && sr_ready;
  wire msk = sr_op1 == 3'h0 && sr_crn == 4'h4 && sr_crm == 4'h6 && sr_op2 == 3'h0;
  wire ns1 = sr_el == 2'h1 && security_state_bit && sysreg_enable_level1;
  wire mon = el3_present && secure_monitor_fiq_route && secure_monitor_irq_route;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  virt_redirect_a: assert property (
    tk && msk && ns1 && (hyp_fiq_route || hyp_irq_route) |=> sr_virtual && !sr_trap)
    else $error("mask access not redirected to virtual copy");
  level_trap_a: assert property (
    tk && msk && sr_el == 2'h1 && !sysreg_enable_level1 |=> sr_trap && sr_trap_el == 2'h1)
    else $error("disabled level 1 access not trapped to level 1");
  common_trap_a: assert property (
    tk && msk && ns1 && !hyp_fiq_route && !hyp_irq_route && hyp_common_reg_trap
    |=> sr_trap && sr_trap_el == 2'h2)
    else $error("common register trap not taken to level 2");
  monitor_trap_a: assert property (
    tk && msk && sr_el == 2'h2 && sysreg_enable_level2 && mon |=> sr_trap && sr_trap_el == 2'h3)
    else $error("level 2 access not trapped to level 3");
  irq_filter_a: assert property (
    irq_signal == ($past(pend_valid) && $past(pend_priority) < priority_mask_value))
    else $error("pending signal disagrees with mask");
  run_readonly_a: assert property (
    tk && sr_write && sr_crn == 4'hC && sr_crm == 4'hB && sr_op2 == 3'h3 |=> sr_undef)
    else $error("write to running priority not refused");
  gen_fields_a: assert property (
    $rose(gen_valid) |-> gen_interrupt_identifier == $past(sr_wdata[27:24])
    && gen_routing_mode == $past(sr_wdata[40]))
    else $error("packet identifier or mode differs from written value");
  gen_hold_a: assert property (
    gen_valid && !gen_ready |=> gen_valid && $stable(gen_target_bitmap)
    && $stable(gen_affinity_level_one))
    else $error("packet changed while distributor stalled");
  gen_broadcast_a: assert property (
    gen_valid && gen_routing_mode |-> gen_target_bitmap == 16'h0000
    && (gen_affinity_level_one | gen_affinity_level_two | gen_affinity_level_three) == 8'h00)
    else $error("broadcast packet carries target fields");
  gen_once_a: assert property (
    gen_valid && gen_ready |=> !gen_valid && sr_done)
    else $error("packet not retired after acceptance");
endmodule
bind cpi_regs cpi_regs_assertions chk_u (.*);
`default_nettype wire

// *** sim/cpi_dist_model.sv ***
// distributor stand-in taking generate packets promptly or after a stall
`timescale 1ns/1ps
`default_nettype none
module cpi_dist_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall,
  input wire logic gen_valid,
  output logic gen_ready,
  output logic [7:0] pkt_cnt
);
  logic [1:0] wait_reg;
  // ----------------------------------------------------------------
  // acceptance
  // ----------------------------------------------------------------
  // every packet is taken, target bits are never inspected
  assign gen_ready = gen_valid && (!stall || wait_reg == 2'h3);
  // stall counter and count of accepted packets
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 2'h0;
      pkt_cnt <= 8'h00;
    end else if (gen_ready) begin
      wait_reg <= 2'h0;
      pkt_cnt <= pkt_cnt + 8'h01;
    end else if (gen_valid) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the priority and generate register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rstn, sr_req, sr_write, stall, act_valid, act_all_dropped, pend_valid;
  logic sr_ready, sr_done, sr_trap, sr_virtual, sr_undef, irq_signal, gen_valid, gen_ready;
  logic gen_routing_mode;
  logic [1:0] sr_el, sr_trap_el;
  logic [2:0] sr_op2;
  logic [3:0] sr_crn, sr_crm, gen_interrupt_identifier;
  logic [5:0] ctl;
  logic [7:0] act_priority, pend_priority, priority_mask_value, pkt_cnt;
  logic [7:0] gen_affinity_level_three, gen_affinity_level_two, gen_affinity_level_one;
  logic [15:0] gen_target_bitmap;
  logic [44:0] pkt;
  logic [63:0] sr_wdata, sr_rdata;
  int n_errors = 0;
  int total_checks = 0;
  // row: write, register (0 mask, 1 running, 2 generate), level,
  // controls {sre off, ns, fiq route, irq route, common trap, monitor},
  // data, outcome {trap, level, virtual, undef}, read byte
  typedef struct packed {
    logic w;
    logic [1:0] sel;
    logic [1:0] el;
    logic [5:0] ctl;
    logic [7:0] wd;
    logic [4:0] ex;
    logic [7:0] rd;
  } cpi_row_t;
  cpi_row_t rows [20] = '{
    '{1'h0, 2'h0, 2'h3, 6'h00, 8'h00, 5'h00, 8'h00},
    '{1'h1, 2'h0, 2'h3, 6'h00, 8'h80, 5'h00, 8'h00},
    '{1'h0, 2'h0, 2'h3, 6'h00, 8'h00, 5'h00, 8'h80},
    '{1'h0, 2'h0, 2'h1, 6'h18, 8'h00, 5'h02, 8'h00},
    '{1'h1, 2'h0, 2'h1, 6'h14, 8'h11, 5'h02, 8'h00},
    '{1'h0, 2'h0, 2'h1, 6'h10, 8'h00, 5'h00, 8'h80},
    '{1'h0, 2'h0, 2'h1, 6'h20, 8'h00, 5'h14, 8'h00},
    '{1'h0, 2'h1, 2'h2, 6'h20, 8'h00, 5'h18, 8'h00},
    '{1'h1, 2'h2, 2'h3, 6'h20, 8'h00, 5'h1C, 8'h00},
    '{1'h0, 2'h0, 2'h1, 6'h12, 8'h00, 5'h18, 8'h00},
    '{1'h0, 2'h1, 2'h1, 6'h12, 8'h00, 5'h18, 8'h00},
    '{1'h0, 2'h0, 2'h1, 6'h01, 8'h00, 5'h1C, 8'h00},
    '{1'h0, 2'h0, 2'h2, 6'h01, 8'h00, 5'h1C, 8'h00},
    '{1'h0, 2'h0, 2'h1, 6'h11, 8'h00, 5'h1C, 8'h00},
    '{1'h0, 2'h1, 2'h1, 6'h19, 8'h00, 5'h02, 8'h00},
    '{1'h1, 2'h1, 2'h3, 6'h00, 8'h00, 5'h01, 8'h00},
    '{1'h0, 2'h1, 2'h3, 6'h00, 8'h00, 5'h00, 8'hFF},
    '{1'h0, 2'h2, 2'h3, 6'h00, 8'h00, 5'h01, 8'h00},
    '{1'h0, 2'h0, 2'h0, 6'h00, 8'h00, 5'h01, 8'h00},
    '{1'h1, 2'h2, 2'h1, 6'h14, 8'h00, 5'h18, 8'h00}
  };
  cpi_regs dut_u (
    .*,
    .sr_op1(3'h0),
    .security_state_bit(ctl[4]),
    .hyp_fiq_route(ctl[3]),
    .hyp_irq_route(ctl[2]),
    .hyp_common_reg_trap(ctl[1]),
    .sysreg_enable_level1(!ctl[5]),
    .sysreg_enable_level2(!ctl[5]),
    .sysreg_enable_level3(!ctl[5]),
    .el3_present(1'h1),
    .secure_monitor_fiq_route(ctl[0]),
    .secure_monitor_irq_route(ctl[0])
  );
  cpi_dist_model peer_u (.*);
  // ----------------------------------------------------------------
  // clock, packet capture, helpers
  // ----------------------------------------------------------------
  always #4 clk = ~clk;
  // packet as handed over at the accepting edge
  always @(posedge clk) begin
    if (gen_valid && gen_ready) begin
      pkt <= {gen_interrupt_identifier, gen_routing_mode, gen_affinity_level_three,
              gen_affinity_level_two, gen_affinity_level_one, gen_target_bitmap};
    end
  end
  // one register access, held until taken, returns at the completion pulse
  task automatic acc(input logic w, input logic [1:0] sel, input logic [1:0] el,
                     input logic [63:0] wd);
    int k;
    k = 0;
    @(negedge clk);
    sr_write = w;
    sr_el = el;
    sr_wdata = wd;
    case (sel)
      2'h0: {sr_crn, sr_crm, sr_op2} = {4'h4, 4'h6, 3'h0};
      2'h1: {sr_crn, sr_crm, sr_op2} = {4'hC, 4'hB, 3'h3};
      default: {sr_crn, sr_crm, sr_op2} = {4'hC, 4'hB, 3'h7};
    endcase
    sr_req = 1'b1;
    while (sr_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    sr_req = 1'b0;
    while (sr_done !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk({63'h0, sr_done}, 64'h1);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {sr_req, sr_write, stall, act_valid, act_all_dropped, pend_valid} = '0;
    {sr_el, sr_crn, sr_crm, sr_op2, ctl, act_priority, pend_priority, sr_wdata} = '0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    // table of ordinary accesses
    foreach (rows[i]) begin
      ctl = rows[i].ctl;
      acc(rows[i].w, rows[i].sel, rows[i].el, {56'h0, rows[i].wd});
      chk({58'h0, sr_done, sr_trap, sr_trap ? sr_trap_el : 2'h0, sr_virtual, sr_undef},
          {58'h0, 1'h1, rows[i].ex});
      chk(sr_rdata, {56'h0, rows[i].rd});
    end
    chk({56'h0, pkt_cnt}, 64'h0);
    // running priority from the active interrupt, then after a drop
    ctl = 6'h00;
    act_valid = 1'b1;
    act_priority = 8'hA5;
    acc(1'b0, 2'h1, 2'h3, 64'h0);
    chk(sr_rdata, 64'hA4);
    act_all_dropped = 1'b1;
    acc(1'b0, 2'h1, 2'h3, 64'h0);
    chk(sr_rdata, 64'hFF);
    // mask boundary on the pending signal
    acc(1'b1, 2'h0, 2'h3, 64'h40);
    chk({56'h0, priority_mask_value}, 64'h40);
    pend_valid = 1'b1;
    pend_priority = 8'h3F;
    @(negedge clk);
    chk({63'h0, irq_signal}, 64'h1);
    pend_priority = 8'h40;
    @(negedge clk);
    chk({63'h0, irq_signal}, 64'h0);
    pend_valid = 1'b0;
    // targeted packet against a stalling distributor, reserved bits set
    stall = 1'b1;
    acc(1'b1, 2'h2, 2'h3, 64'hFFAB_FEC2_F5CD_893C);
    chk({19'h0, pkt}, {19'h0, 4'h5, 1'h0, 24'hABC2CD, 16'h893C});
    // broadcast packet, target fields must drop out
    stall = 1'b0;
    acc(1'b1, 2'h2, 2'h3, 64'h00FF_01FF_0AFF_FFFF);
    chk({19'h0, pkt}, {19'h0, 4'hA, 1'h1, 40'h0});
    chk({56'h0, pkt_cnt}, 64'h2);
    // second reset in mid-run brings the mask back
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    acc(1'b0, 2'h0, 2'h3, 64'h0);
    chk(sr_rdata, 64'h0);
    stop_test();
  end
  // whole run is under a hundred cycles, so 50 us means a hang
  initial begin
    #50000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
